// *** shared/mrf_pkg.sv ***
// Shared constants, types and states of the serial frame handler
package mrf_pkg;

  // ----------------------------------------------------------------
  // Frame fields
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_BCAST = 8'h00;
  localparam logic [7:0] ADDR_MAX = 8'hf7;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_ILLEGAL_FUNC = 8'h01;
  localparam logic [8:0] MIN_FRAME_LEN = 9'h004;
  localparam logic [8:0] MAX_FRAME_LEN = 9'h100;
  localparam logic [8:0] DATA_OFFSET = 9'h002;

  // Supported function codes
  localparam logic [7:0] FC_READ_HOLD = 8'h03;
  localparam logic [7:0] FC_WRITE_SINGLE = 8'h06;
  localparam logic [7:0] FC_DIAG = 8'h08;
  localparam logic [7:0] FC_WRITE_MULTI = 8'h10;
  localparam logic [7:0] FC_ACCESS_LOG = 8'h46;

  // ----------------------------------------------------------------
  // Check sequence
  // ----------------------------------------------------------------
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'ha001;
  localparam logic [15:0] CRC_RESIDUE = 16'h0000;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ_DEF = 100_000_000;
  localparam int unsigned GAP_CHARS_X2 = 7;
  localparam int unsigned GAP_DIV = 2;
  localparam int unsigned START_BITS = 1;
  localparam int unsigned DATA_BITS = 8;
  localparam int unsigned BAUD_TAB [8] = '{4800, 9600, 19200, 38400, 57600, 76800,
    115200, 19200};
  localparam logic [23:0] GAP_RST = 24'hffffff;
  localparam int unsigned FIFO_DEPTH = 16;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic last;
    logic [7:0] data;
  } mrf_byte_s;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] func;
    logic bcast;
    logic [8:0] len;
  } mrf_qinfo_s;

  typedef enum logic [7:0] {
    TX_IDLE = 8'h01,
    TX_GAP = 8'h02,
    TX_ADDR = 8'h04,
    TX_FUNC = 8'h08,
    TX_EXC = 8'h10,
    TX_PAY = 8'h20,
    TX_CRCL = 8'h40,
    TX_CRCH = 8'h80
  } mrf_tx_e;

endpackage

// *** logic/mrf_crc.sv ***
// Byte-wide running check-sequence register
`timescale 1ns/1ns
`default_nettype none
module mrf_crc (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic ce,
  // Control and data
  input wire logic clr,
  input wire logic en,
  input wire logic [7:0] data,
  output logic [15:0] crc
);

  // One byte, least significant bit first, reflected polynomial
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] v;
    v = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++)
    begin
      v = v[0] ? ((v >> 1) ^ mrf_pkg::CRC_POLY) : (v >> 1);
    end
    return v;
  endfunction

  // Clear restarts from the seed, a byte may follow in the same cycle
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      crc <= mrf_pkg::CRC_INIT;
    else if (ce)
    begin
      if (en)
        crc <= crc_step(clr ? mrf_pkg::CRC_INIT : crc, data);
      else if (clr)
        crc <= mrf_pkg::CRC_INIT;
    end
  end

endmodule
`default_nettype wire

// *** logic/mrf_fifo.sv ***
// Small synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ns
`default_nettype none
module mrf_fifo #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 16
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic flush,
  // Fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_r;
  logic [AW:0] rd_r;
  logic full;
  logic empty;

  // Pointers carry one extra bit to tell full from empty
  assign full = (wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]);
  assign empty = (wr_r == rd_r);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rd_r[AW-1:0]];

  // Storage
  always_ff @(posedge sys_clk)
  begin
    if (ce && in_valid && !full)
      mem[wr_r[AW-1:0]] <= in_data;
  end

  // Pointer update
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wr_r <= '0;
      rd_r <= '0;
    end
    else if (ce)
    begin
      if (flush)
      begin
        wr_r <= '0;
        rd_r <= '0;
      end
      else
      begin
        if (in_valid && !full)
          wr_r <= wr_r + 1'b1;
        if (out_ready && !empty)
          rd_r <= rd_r + 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// *** logic/mrf_frame_handler.sv ***
// Server-side serial frame handler: gap framing, checks, responses
`timescale 1ns/1ns
`default_nettype none
module mrf_frame_handler #(
  parameter int unsigned CLK_HZ = mrf_pkg::CLK_HZ_DEF
) (
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic ce,
  // Line settings
  input wire logic [7:0] station_number_setting,
  input wire logic [2:0] baud_sel,
  input wire logic parity_en,
  input wire logic two_stop,
  // Received characters from the serial receiver
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_err,
  // Query data towards the application
  output logic q_valid,
  output logic [7:0] q_data,
  output logic q_done,
  output logic q_drop,
  output mrf_pkg::mrf_qinfo_s q_info,
  // Response control from the application
  input wire logic rsp_start,
  input wire logic rsp_exc,
  input wire logic [7:0] rsp_exc_code,
  output logic rsp_pending,
  output logic rsp_busy,
  // Response payload from the application
  input wire logic pl_valid,
  input wire mrf_pkg::mrf_byte_s pl_data,
  output logic pl_ready,
  // Characters towards the serial transmitter
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready
);

  // ----------------------------------------------------------------
  // Gap timing
  // ----------------------------------------------------------------
  logic [23:0] gap_cyc_r;
  logic [23:0] idle_cnt_r;
  logic gap_hit;
  int unsigned char_bits;
  int unsigned bit_cyc;

  // Parity forces a single stop bit
  always_comb
  begin
    char_bits = mrf_pkg::START_BITS + mrf_pkg::DATA_BITS + 1;
    if (parity_en || two_stop)
      char_bits = char_bits + 1;
    bit_cyc = CLK_HZ / mrf_pkg::BAUD_TAB[baud_sel];
  end

  // Gap of 3.5 characters, rounded up to whole cycles
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      gap_cyc_r <= mrf_pkg::GAP_RST;
    else if (ce)
      gap_cyc_r <= 24'((bit_cyc * char_bits * mrf_pkg::GAP_CHARS_X2 + mrf_pkg::GAP_DIV - 1)
        / mrf_pkg::GAP_DIV);
  end

  // Idle time since the last character, saturating at the gap
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      idle_cnt_r <= '0;
    else if (ce)
    begin
      if (rx_valid)
        idle_cnt_r <= '0;
      else if (!gap_hit)
        idle_cnt_r <= idle_cnt_r + 24'h000001;
    end
  end

  assign gap_hit = (idle_cnt_r >= gap_cyc_r);

  // ----------------------------------------------------------------
  // Receive framing
  // ----------------------------------------------------------------
  logic synced_r;
  logic in_frame_r;
  logic [8:0] cnt_r;
  logic err_r;
  logic [7:0] addr_r;
  logic [7:0] func_r;
  logic [7:0] hold0_r;
  logic [7:0] hold1_r;
  logic [15:0] rx_crc;
  logic rx_first;
  logic frame_end;
  logic for_us;
  logic bcast;
  logic func_ok;
  logic frame_ok;

  assign rx_first = rx_valid && synced_r && !in_frame_r;
  assign frame_end = gap_hit && in_frame_r;
  assign bcast = (addr_r == mrf_pkg::ADDR_BCAST);
  assign for_us = bcast
    || (addr_r == station_number_setting && addr_r <= mrf_pkg::ADDR_MAX);
  assign frame_ok = !err_r && (cnt_r >= mrf_pkg::MIN_FRAME_LEN)
    && (rx_crc == mrf_pkg::CRC_RESIDUE);

  // Function code table
  always_comb
  begin
    case (func_r)
      mrf_pkg::FC_READ_HOLD,
      mrf_pkg::FC_WRITE_SINGLE,
      mrf_pkg::FC_DIAG,
      mrf_pkg::FC_WRITE_MULTI,
      mrf_pkg::FC_ACCESS_LOG: func_ok = 1'b1;
      default: func_ok = 1'b0;
    endcase
  end

  // Running check over every received byte of the frame
  mrf_crc u_rx_crc (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .ce(ce),
    .clr(rx_first),
    .en(rx_valid && (rx_first || in_frame_r)),
    .data(rx_data),
    .crc(rx_crc)
  );

  // Line sync: first gap after reset arms the receiver
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      synced_r <= 1'b0;
    else if (ce && gap_hit)
      synced_r <= 1'b1;
  end

  // Frame state, byte count, header capture
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      in_frame_r <= 1'b0;
      cnt_r <= '0;
      err_r <= 1'b0;
      addr_r <= '0;
      func_r <= '0;
      hold0_r <= '0;
      hold1_r <= '0;
    end
    else if (ce)
    begin
      if (frame_end)
        in_frame_r <= 1'b0;
      if (rx_valid && (rx_first || in_frame_r))
      begin
        in_frame_r <= 1'b1;
        cnt_r <= rx_first ? 9'h001 : cnt_r + 9'h001;
        err_r <= (rx_first ? 1'b0 : err_r) || rx_err
          || (!rx_first && cnt_r == mrf_pkg::MAX_FRAME_LEN);
        if (rx_first)
          addr_r <= rx_data;
        if (!rx_first && cnt_r == 9'h001)
          func_r <= rx_data;
        hold0_r <= rx_data;
        hold1_r <= hold0_r;
      end
    end
  end

  // Data bytes trail by two so the closing check bytes never leak out
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      q_valid <= 1'b0;
      q_data <= '0;
    end
    else if (ce)
    begin
      q_valid <= rx_valid && in_frame_r && for_us && !rx_first
        && (cnt_r >= mrf_pkg::MIN_FRAME_LEN);
      q_data <= hold1_r;
    end
  end

  // Frame verdict at the closing gap
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      q_done <= 1'b0;
      q_drop <= 1'b0;
      q_info <= '0;
    end
    else if (ce)
    begin
      q_done <= frame_end && for_us && frame_ok && func_ok;
      q_drop <= frame_end && for_us && !frame_ok;
      if (frame_end)
      begin
        q_info.addr <= addr_r;
        q_info.func <= func_r;
        q_info.bcast <= bcast;
        q_info.len <= cnt_r - mrf_pkg::MIN_FRAME_LEN;
      end
    end
  end

  // ----------------------------------------------------------------
  // Response transmit
  // ----------------------------------------------------------------
  mrf_pkg::mrf_tx_e tx_st_r;
  logic [7:0] rsp_addr_r;
  logic [7:0] rsp_func_r;
  logic [7:0] exc_code_r;
  logic exc_r;
  logic slot_free;
  logic load;
  logic [7:0] load_byte;
  logic [15:0] tx_crc;
  logic fo_valid;
  mrf_pkg::mrf_byte_s fo_data;
  logic fo_ready;
  logic own_exc;

  assign own_exc = frame_end && for_us && frame_ok && !func_ok && !bcast;
  assign slot_free = !tx_valid || tx_ready;
  // Busy until the closing check byte has left the output register
  assign rsp_busy = (tx_st_r != mrf_pkg::TX_IDLE) || tx_valid;
  assign fo_ready = (tx_st_r == mrf_pkg::TX_PAY) && slot_free;

  // Payload buffer between application and transmitter
  mrf_fifo #(
    .WIDTH($bits(mrf_pkg::mrf_byte_s)),
    .DEPTH(mrf_pkg::FIFO_DEPTH)
  ) u_pl_fifo (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .ce(ce),
    .flush(frame_end),
    .in_valid(pl_valid),
    .in_data(pl_data),
    .in_ready(pl_ready),
    .out_valid(fo_valid),
    .out_data(fo_data),
    .out_ready(fo_ready)
  );

  // Byte offered to the transmitter in each state
  always_comb
  begin
    load = 1'b0;
    load_byte = 8'h00;
    case (tx_st_r)
      mrf_pkg::TX_ADDR:
      begin
        load = slot_free;
        load_byte = rsp_addr_r;
      end
      mrf_pkg::TX_FUNC:
      begin
        load = slot_free;
        load_byte = exc_r ? (rsp_func_r | mrf_pkg::EXC_FLAG) : rsp_func_r;
      end
      mrf_pkg::TX_EXC:
      begin
        load = slot_free;
        load_byte = exc_code_r;
      end
      mrf_pkg::TX_PAY:
      begin
        load = slot_free && fo_valid;
        load_byte = fo_data.data;
      end
      mrf_pkg::TX_CRCL:
      begin
        load = slot_free;
        load_byte = tx_crc[7:0];
      end
      mrf_pkg::TX_CRCH:
      begin
        load = slot_free;
        load_byte = tx_crc[15:8];
      end
      default:
      begin
        load = 1'b0;
        load_byte = 8'h00;
      end
    endcase
  end

  // Check over address, function and data of the response
  mrf_crc u_tx_crc (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .ce(ce),
    .clr(tx_st_r == mrf_pkg::TX_GAP),
    .en(load && tx_st_r != mrf_pkg::TX_CRCL && tx_st_r != mrf_pkg::TX_CRCH),
    .data(load_byte),
    .crc(tx_crc)
  );

  // Registered output character
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tx_valid <= 1'b0;
      tx_data <= '0;
    end
    else if (ce)
    begin
      if (load)
      begin
        tx_valid <= 1'b1;
        tx_data <= load_byte;
      end
      else if (tx_ready)
        tx_valid <= 1'b0;
    end
  end

  // Pending query that is owed exactly one response
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rsp_pending <= 1'b0;
      rsp_addr_r <= '0;
      rsp_func_r <= '0;
    end
    else if (ce)
    begin
      if (frame_end && for_us && frame_ok && !bcast)
      begin
        rsp_pending <= 1'b1;
        rsp_addr_r <= addr_r;
        rsp_func_r <= func_r;
      end
      else if (tx_st_r == mrf_pkg::TX_CRCH && load)
        rsp_pending <= 1'b0;
    end
  end

  // Response sequencer
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tx_st_r <= mrf_pkg::TX_IDLE;
      exc_r <= 1'b0;
      exc_code_r <= '0;
    end
    else if (ce)
    begin
      case (tx_st_r)
        mrf_pkg::TX_IDLE:
        begin
          if (own_exc)
          begin
            exc_r <= 1'b1;
            exc_code_r <= mrf_pkg::EXC_ILLEGAL_FUNC;
            tx_st_r <= mrf_pkg::TX_GAP;
          end
          else if (rsp_start && rsp_pending && !in_frame_r)
          begin
            exc_r <= rsp_exc;
            exc_code_r <= rsp_exc_code;
            tx_st_r <= mrf_pkg::TX_GAP;
          end
        end
        mrf_pkg::TX_GAP:
          if (gap_hit)
            tx_st_r <= mrf_pkg::TX_ADDR;
        mrf_pkg::TX_ADDR:
          if (load)
            tx_st_r <= mrf_pkg::TX_FUNC;
        mrf_pkg::TX_FUNC:
          if (load)
            tx_st_r <= exc_r ? mrf_pkg::TX_EXC : mrf_pkg::TX_PAY;
        mrf_pkg::TX_EXC:
          if (load)
            tx_st_r <= mrf_pkg::TX_CRCL;
        mrf_pkg::TX_PAY:
          if (load && fo_data.last)
            tx_st_r <= mrf_pkg::TX_CRCL;
        mrf_pkg::TX_CRCL:
          if (load)
            tx_st_r <= mrf_pkg::TX_CRCH;
        mrf_pkg::TX_CRCH:
          if (load)
            tx_st_r <= mrf_pkg::TX_IDLE;
        default:
          tx_st_r <= mrf_pkg::TX_IDLE;
      endcase
    end
  end

endmodule
`default_nettype wire

// *** bench/mrf_sva.sv ***
// Port checker for the frame handler
`timescale 1ns/1ns
`default_nettype none
module mrf_sva (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Watched ports
  input wire logic [7:0] station_number_setting,
  input wire logic q_done,
  input wire logic q_drop,
  input wire mrf_pkg::mrf_qinfo_s q_info,
  input wire logic rsp_start,
  input wire logic rsp_pending,
  input wire logic rsp_busy,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_ready
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);
  logic [8:0] idx_r;
  logic sup;
  // Supported function lookup
  assign sup = q_info.func inside {mrf_pkg::FC_READ_HOLD, mrf_pkg::FC_WRITE_SINGLE,
    mrf_pkg::FC_DIAG, mrf_pkg::FC_WRITE_MULTI, mrf_pkg::FC_ACCESS_LOG};
  // Accepted response bytes
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      idx_r <= 9'h000;
    else if (!rsp_busy)
      idx_r <= 9'h000;
    else if (tx_valid && tx_ready)
      idx_r <= idx_r + 9'h001;
  end
  property p_tx_busy;
    tx_valid |-> rsp_busy;
  endproperty
  a_tx_busy: assert property (p_tx_busy) else $error("tx outside response");
  property p_start_pend;
    rsp_start && !rsp_pending && !rsp_busy |=> !rsp_busy;
  endproperty
  a_start_pend: assert property (p_start_pend) else $error("start without query");
  property p_addr;
    $rose(tx_valid) |-> tx_data == station_number_setting;
  endproperty
  a_addr: assert property (p_addr) else $error("response address wrong");
  property p_func;
    tx_valid && idx_r == 9'h001 |-> tx_data[6:0] == q_info.func[6:0];
  endproperty
  a_func: assert property (p_func) else $error("function byte wrong");
  property p_exc;
    tx_valid && idx_r == 9'h001 && !sup |-> tx_data == (q_info.func | mrf_pkg::EXC_FLAG);
  endproperty
  a_exc: assert property (p_exc) else $error("unsupported code not flagged");
  property p_pend;
    $rose(rsp_pending) |-> q_info.addr == station_number_setting && !q_info.bcast;
  endproperty
  a_pend: assert property (p_pend) else $error("pending for foreign query");
  property p_end_once;
    q_done |=> !q_done && !q_drop;
  endproperty
  a_end_once: assert property (p_end_once) else $error("frame ended twice");
  property p_drop_quiet;
    q_drop && !rsp_busy && !rsp_pending |=> !rsp_busy [*8];
  endproperty
  a_drop_quiet: assert property (p_drop_quiet) else $error("answer to bad frame");
  property p_tx_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx byte lost");
  property p_gap;
    $rose(rsp_busy) |-> !tx_valid ##1 !tx_valid;
  endproperty
  a_gap: assert property (p_gap) else $error("no gap before response");
  c_bcast: cover property (q_done && q_info.bcast);
  c_drop: cover property (q_drop);
  c_exc: cover property (tx_valid && idx_r == 9'h001 && tx_data[7]);
endmodule
bind mrf_frame_handler mrf_sva mrf_sva_i (.sys_clk(sys_clk), .arst_n(arst_n),
  .station_number_setting(station_number_setting), .q_done(q_done), .q_drop(q_drop),
  .q_info(q_info), .rsp_start(rsp_start), .rsp_pending(rsp_pending),
  .rsp_busy(rsp_busy), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
`default_nettype wire

// *** bench/mrf_client_model.sv ***
// Client controller model on the serial character side
`timescale 1ns/1ns
`default_nettype none
module mrf_client_model (
  // Clock
  input wire logic sys_clk,
  // Stall control
  input wire logic slow,
  // Query characters
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_err,
  // Response characters
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready
);
  logic [7:0] got[$];
  initial
  begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_err = 1'b0;
  end
  // Whole frame back to back, idle line scrambled after
  task automatic send(input logic [7:0] b[$], input int err_i);
    foreach (b[i])
    begin
      @(negedge sys_clk);
      rx_valid = 1'b1;
      rx_data = b[i];
      rx_err = (i == err_i);
    end
    @(negedge sys_clk);
    rx_valid = 1'b0;
    rx_err = 1'b0;
    rx_data = ~rx_data;
  endtask
  // Stall pattern on acceptance
  always @(negedge sys_clk)
    tx_ready <= slow ? ~tx_ready : 1'b1;
  // Collect response characters
  always @(posedge sys_clk)
    if (tx_valid && tx_ready)
      got.push_back(tx_data);
endmodule
`default_nettype wire

// *** bench/tb_top.sv ***
// Testbench of the frame handler
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  localparam int unsigned CLK = 230400;
  localparam logic [7:0] STN = 8'h11;
  typedef struct {logic [7:0] a; logic [7:0] f; logic bad;
    int rsp; int npl; logic slow;} mrf_row_s;
  mrf_row_s rows[10] = '{'{STN, 8'h03, 0, 1, 2, 0}, '{STN, 8'h06, 0, 1, 2, 0},
    '{STN, 8'h08, 0, 1, 2, 0}, '{STN, 8'h10, 0, 1, 16, 1}, '{STN, 8'h46, 0, 3, 0, 0},
    '{8'h00, 8'h06, 0, 0, 0, 0}, '{8'h12, 8'h03, 0, 0, 0, 0}, '{STN, 8'h41, 0, 2, 0, 1},
    '{8'h00, 8'h41, 0, 0, 0, 0}, '{STN, 8'h03, 1, 0, 0, 0}};
  logic sys_clk, arst_n, rsp_start, rsp_exc, pl_valid, pl_ready, slow, q_valid, q_done, q_drop;
  logic rsp_pending, rsp_busy, rx_valid, rx_err, tx_valid, tx_ready;
  logic ce, two_stop;
  logic [7:0] rx_data, tx_data, q_data, rsp_exc_code;
  mrf_pkg::mrf_qinfo_s q_info;
  mrf_pkg::mrf_byte_s pl_data;
  int n_fail, comparisons, cyc, nv, nd, np;
  mrf_frame_handler #(.CLK_HZ(CLK)) mrf_frame_handler_i (.sys_clk(sys_clk), .arst_n(arst_n),
    .ce(ce), .station_number_setting(STN), .baud_sel(3'h6), .parity_en(1'b0),
    .two_stop(two_stop), .rx_valid(rx_valid), .rx_data(rx_data), .rx_err(rx_err),
    .q_valid(q_valid), .q_data(q_data), .q_done(q_done), .q_drop(q_drop), .q_info(q_info),
    .rsp_start(rsp_start), .rsp_exc(rsp_exc), .rsp_exc_code(rsp_exc_code),
    .rsp_pending(rsp_pending), .rsp_busy(rsp_busy), .pl_valid(pl_valid), .pl_data(pl_data),
    .pl_ready(pl_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
  mrf_client_model mrf_client_model_i (.sys_clk(sys_clk), .slow(slow), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_err(rx_err), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready));
  // Event counters and run ceiling
  always @(posedge sys_clk)
  begin
    nv += q_valid;
    nd += q_done;
    np += q_drop;
    cyc++;
    if (cyc == 30000)
    begin
      n_fail++;
      tally_and_finish();
    end
  end
  function automatic logic [15:0] crc16(input logic [7:0] b[$]);
    logic [15:0] c;
    c = mrf_pkg::CRC_INIT;
    foreach (b[i])
    begin
      c ^= {8'h00, b[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ mrf_pkg::CRC_POLY : c >> 1;
    end
    return c;
  endfunction
  task automatic check(input logic ok, input string m);
    comparisons++;
    if (ok !== 1'b1)
    begin
      n_fail++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask
  // Collect a response and compare it byte by byte
  task automatic expect_tx(input logic [7:0] e[$]);
    for (int k = 0; k < 600 && (k < 150 || rsp_busy); k++) @(negedge sys_clk);
    check(mrf_client_model_i.got.size() == e.size(), "response length");
    foreach (e[i]) check(mrf_client_model_i.got[i] === e[i], "response byte");
    mrf_client_model_i.got.delete();
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial
  begin
    logic [7:0] fr[$], ex[$];
    logic [15:0] c;
    logic ok_a, sp, dn;
    int v0, d0, p0;
    {arst_n, rsp_start, rsp_exc, pl_valid, slow} = 5'h00;
    ce = 1'b1;
    two_stop = 1'b0;
    rsp_exc_code = 8'h03;
    pl_data = '0;
    repeat (8) @(negedge sys_clk);
    check(pl_ready === 1'b1 && tx_valid === 1'b0 && rsp_pending === 1'b0, "reset values");
    arst_n = 1'b1;
    repeat (150) @(negedge sys_clk);
    foreach (rows[r])
    begin
      fr = '{rows[r].a, rows[r].f, 8'h00, 8'h01, 8'h00, 8'h02};
      c = crc16(fr) ^ {15'h0000, rows[r].bad};
      fr.push_back(c[7:0]);
      fr.push_back(c[15:8]);
      ok_a = rows[r].a == STN || rows[r].a == 8'h00;
      sp = rows[r].f inside {8'h03, 8'h06, 8'h08, 8'h10, 8'h46};
      dn = ok_a && sp && !rows[r].bad;
      {v0, d0, p0} = {nv, nd, np};
      slow = rows[r].slow;
      mrf_client_model_i.send(fr, -1);
      repeat (120) @(negedge sys_clk);
      if (dn)
        check(nv - v0 == 4 && q_info.bcast === (rows[r].a == 8'h00), "query data");
      check(nd - d0 == dn, "query done");
      check(np - p0 == (ok_a && rows[r].bad), "query drop");
      ex = '{rows[r].a, rows[r].rsp == 1 ? rows[r].f : rows[r].f | 8'h80};
      for (int k = 0; k < rows[r].npl; k++)
      begin
        pl_valid = 1'b1;
        pl_data.last = k == rows[r].npl - 1;
        pl_data.data = 8'h30 + k[7:0];
        ex.push_back(pl_data.data);
        @(negedge sys_clk);
      end
      pl_valid = 1'b0;
      if (rows[r].npl == 16) check(pl_ready === 1'b0, "fifo full");
      if (rows[r].rsp == 2) ex.push_back(8'h01);
      if (rows[r].rsp == 3) ex.push_back(8'h03);
      if (rows[r].rsp != 0)
      begin
        c = crc16(ex);
        ex.push_back(c[7:0]);
        ex.push_back(c[15:8]);
      end
      else
        ex.delete();
      rsp_exc = rows[r].rsp == 3;
      rsp_start = rows[r].rsp == 1 || rows[r].rsp == 3;
      @(negedge sys_clk);
      rsp_start = 1'b0;
      expect_tx(ex);
    end
    rsp_start = 1'b1;
    @(negedge sys_clk);
    rsp_start = 1'b0;
    ex.delete();
    expect_tx(ex);
    p0 = np;
    fr = '{STN, 8'h03, 8'h00, 8'h01};
    c = crc16(fr);
    fr.push_back(c[7:0]);
    fr.push_back(c[15:8]);
    mrf_client_model_i.send(fr, 2);
    repeat (120) @(negedge sys_clk);
    check(np - p0 == 1, "char error drop");
    ex.delete();
    expect_tx(ex);
    arst_n = 1'b0;
    @(negedge sys_clk);
    check(q_done === 1'b0 && rsp_busy === 1'b0 && pl_ready === 1'b1, "mid-run reset");
    // Release again with two stop bits, then freeze by the enable
    two_stop = 1'b1;
    arst_n = 1'b1;
    repeat (150) @(negedge sys_clk);
    d0 = nd;
    fr = '{STN, 8'h06, 8'h00, 8'h01, 8'h00, 8'h02};
    c = crc16(fr);
    fr.push_back(c[7:0]);
    fr.push_back(c[15:8]);
    ce = 1'b0;
    mrf_client_model_i.send(fr, -1);
    repeat (120) @(negedge sys_clk);
    check(nd == d0 && rsp_pending === 1'b0, "frozen by enable");
    ce = 1'b1;
    repeat (10) @(negedge sys_clk);
    mrf_client_model_i.send(fr, -1);
    repeat (120) @(negedge sys_clk);
    check(nd - d0 == 1 && q_info.func === 8'h06, "resync after reset");
    tally_and_finish();
  end
endmodule
`default_nettype wire
